//--- verilog/pin_mux_map.svh
// Register offsets, field positions and reset values of the pin controls
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

`define PIN7_CONTROL_ADDR 8'h29
`define PIN6_CONTROL_ADDR 8'h2A
`define PIN5_CONTROL_ADDR 8'h2B
`define PIN4_CONTROL_ADDR 8'h2C
`define PIN3_CONTROL_ADDR 8'h2D
`define PIN2_CONTROL_ADDR 8'h2E
`define PIN1_CONTROL_ADDR 8'h2F
`define PIN_COUNT         7
`define MODE_HI_BIT       7
`define MODE_LO_BIT       6
`define POLARITY_BIT      5
`define FUNC_HI_BIT       4
`define CONTROL_RESET     8'h00

`endif

//--- verilog/pin_mux_pkg.sv
// Types shared by the multifunction pin control logic
package pin_mux_pkg;

  typedef enum logic [1:0] {
    MODE_RECEIVER_INPUT = 2'h0,
    MODE_MUTE           = 2'h1,
    MODE_GENERAL_LOW    = 2'h2,
    MODE_GENERAL_HIGH   = 2'h3
  } pin_mode_t;

  typedef struct packed {
    pin_mode_t  pin_mode;
    logic       polarity;
    logic [4:0] function_bits;
  } pin_control_t;

  // Per-channel mute requests from the DAC
  typedef struct packed {
    logic mute_out_a1;
    logic mute_out_b1;
    logic mute_out_a2;
    logic mute_out_b2;
    logic mute_out_a3;
    logic mute_out_b3;
  } channel_mutes_t;

  // One pin: output level, output enable (low drives), receiver select
  typedef struct packed {
    logic level;
    logic enable_n;
    logic receiver;
  } pin_drive_t;

endpackage

//--- verilog/multifunction_pin_control.sv
// Control registers and pin drivers of the seven multifunction pins
//
// Summary of operation
// - Two-bit mode: receiver input, mute, general low/overflow, drive high.
// - Receiver input mode ignores the polarity bit.
// - Mute mode: polarity 0 is active low, 1 active high.
// - General low/overflow and drive-high modes ignore the polarity bit.
// - Receiver input mode ignores all five function bits.
// - Mute mode: function bit set maps its channel mute onto the pin.
// - Pin 7: bit4 A1, bit3 B1, bit2 A2+B2, bit1 A3+B3, bit0 reserved.
// - Pins 6,5: A1B1,A2,B2,A3B3; pins 4,3: A1B1,A2B2,A3,B3.
// - Pins 2,1: bit4 A1B1, bit3 A2B2, bit2 A3B3, bits 1:0 reserved.
// - Function 00 drives low push-pull; 11 flags ADC overrange open-drain.
// - Drive-high mode ignores function bits and drives pin high.
// - Function field of every control register resets to zero.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "pin_mux_map.svh"

module multifunction_pin_control
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           reset_i,
  // Register port
  input  wire logic [7:0]     addr_i,
  input  wire logic [7:0]     wdata_i,
  input  wire logic           write_i,
  input  wire logic           read_i,
  output logic      [7:0]     rdata_o,
  // Internal status from the converters
  input  wire channel_mutes_t mutes_i,
  input  wire logic           adc_overrange_i,
  // Pins, index 0 is pin 1
  output pin_drive_t [6:0]    muxed_pin_o
);

  //--------------------------------------------------------------
  // Register file
  //--------------------------------------------------------------

  pin_control_t [6:0] control;
  logic         [2:0] write_index;
  logic               write_hit;

  // Pin n sits at 2Fh - (n - 1); decode to an index
  always_comb begin
    write_hit   = 1'b1;
    write_index = 3'h0;
    if (addr_i == `PIN1_CONTROL_ADDR) begin
      write_index = 3'h0;
    end else if (addr_i == `PIN2_CONTROL_ADDR) begin
      write_index = 3'h1;
    end else if (addr_i == `PIN3_CONTROL_ADDR) begin
      write_index = 3'h2;
    end else if (addr_i == `PIN4_CONTROL_ADDR) begin
      write_index = 3'h3;
    end else if (addr_i == `PIN5_CONTROL_ADDR) begin
      write_index = 3'h4;
    end else if (addr_i == `PIN6_CONTROL_ADDR) begin
      write_index = 3'h5;
    end else if (addr_i == `PIN7_CONTROL_ADDR) begin
      write_index = 3'h6;
    end else begin
      write_hit   = 1'b0;
    end
  end

  // Writes store the whole byte; hints are not enforced
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
        control[i] <= `CONTROL_RESET;
      end
    end else if (write_i && write_hit) begin
      control[write_index] <= wdata_i;
    end
  end

  // Read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (read_i && write_hit) begin
      rdata_o <= control[write_index];
    end else begin
      rdata_o <= 8'h00;
    end
  end

  //--------------------------------------------------------------
  // Converter status inputs, used without synchronisers
  //--------------------------------------------------------------

  // Mutes and overrange come from logic on this clock: no sync needed
  logic a1, b1, a2, b2, a3, b3;
  assign a1 = mutes_i.mute_out_a1;
  assign b1 = mutes_i.mute_out_b1;
  assign a2 = mutes_i.mute_out_a2;
  assign b2 = mutes_i.mute_out_b2;
  assign a3 = mutes_i.mute_out_a3;
  assign b3 = mutes_i.mute_out_b3;

  //--------------------------------------------------------------
  // Mute mapping
  //--------------------------------------------------------------

  // Per pin: which channels each function bit selects, as a mask
  // ordered {a1,b1,a2,b2,a3,b3}
  function automatic logic [5:0] channel_mask(input int pin,
                                              input logic [4:0] f);
    logic [5:0] m;
    m = 6'h00;
    if (pin == 6) begin
      m = {f[4], f[3], f[2], f[2], f[1], f[1]};
    end else if (pin == 5 || pin == 4) begin
      m = {f[4], f[4], f[3], f[2], f[1], f[1]};
    end else if (pin == 3 || pin == 2) begin
      m = {f[4], f[4], f[3], f[3], f[2], f[1]};
    end else begin
      m = {f[4], f[4], f[3], f[3], f[2], f[2]};
    end
    return m;
  endfunction

  logic [5:0] muted_now;
  assign muted_now = {a1, b1, a2, b2, a3, b3};

  //--------------------------------------------------------------
  // Pin drivers
  //--------------------------------------------------------------

  pin_drive_t [6:0] next_pin;

  // Output enable low means driven; open drain only pulls low
  always_comb begin
    for (int i = 0; i < `PIN_COUNT; i++) begin
      logic [5:0] mask;
      logic       active;
      mask = channel_mask(i, control[i].function_bits);
      // Unmapped channels count as muted, so no mapping reads active
      active = &(muted_now | ~mask);
      next_pin[i] = '{level: 1'b0, enable_n: 1'b1, receiver: 1'b0};
      case (control[i].pin_mode)
        MODE_RECEIVER_INPUT: begin
          // Polarity and function ignored, pin stays an input
          next_pin[i].receiver = 1'b1;
        end
        MODE_MUTE: begin
          next_pin[i].enable_n = 1'b0;
          next_pin[i].level    = control[i].polarity ? active
                                                     : ~active;
        end
        MODE_GENERAL_LOW: begin
          // Polarity ignored; bits 1:0 choose driver type
          if (control[i].function_bits[1:0] == 2'h3) begin
            next_pin[i].enable_n = ~adc_overrange_i;
          end else begin
            next_pin[i].enable_n = 1'b0;
          end
        end
        default: begin
          next_pin[i].enable_n = 1'b0;
          next_pin[i].level    = 1'b1;
        end
      endcase
    end
  end

  // Registered so pins never glitch on decode changes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
        muxed_pin_o[i] <= '{level: 1'b0, enable_n: 1'b1, receiver: 1'b1};
      end
    end else begin
      muxed_pin_o <= next_pin;
    end
  end

endmodule

//--- tb/pin_mux_properties.sv
// Port checks for the multifunction pin control
`timescale 1ns/10ps
module pin_mux_properties
  import pin_mux_pkg::*;
(
  // Clock, reset and register port
  input wire logic             clk_i,
  input wire logic             reset_i,
  input wire logic [7:0]       addr_i,
  input wire logic [7:0]       wdata_i,
  input wire logic             write_i,
  input wire logic             read_i,
  input wire logic [7:0]       rdata_o,
  // Converter status and pins
  input wire channel_mutes_t   mutes_i,
  input wire logic             adc_overrange_i,
  input wire pin_drive_t [6:0] muxed_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ------------------------------
  // Register port and pin relations
  // ------------------------------
  rd_idle_a:
    assert property (!$past(read_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a:
    assert property (read_i && !(addr_i inside {[8'h29:8'h2F]})
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  reset_pin_a:
    assert property ($fell(reset_i) |-> muxed_pin_o == {7{3'h3}})
    else $error("pins not in receiver state after reset");
  wr_rd_a:
    assert property (write_i && addr_i inside {[8'h29:8'h2F]} ##1
      read_i && $stable(addr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("read back differs from write");
  recv_pin_a:
    assert property (muxed_pin_o[3].receiver |-> muxed_pin_o[3] == 3'h3)
    else $error("receiver pin driven");
  high_drive_a:
    assert property (muxed_pin_o[6].level |-> !muxed_pin_o[6].enable_n)
    else $error("high level on released pin");
  ovr_drive_a:
    assert property (adc_overrange_i |=> !muxed_pin_o[0].enable_n
      || muxed_pin_o[0].receiver) else $error("overrange not driven");
  pin_hold_a:
    assert property ($stable(mutes_i) && $stable(adc_overrange_i)
      && !$past(write_i) |=> $stable(muxed_pin_o))
    else $error("pin moved without cause");
  // Main scenarios reached
  cover property (muxed_pin_o[0] == 3'h2);
  cover property (muxed_pin_o[6] == 3'h4);
  cover property (rdata_o != 8'h00);
endmodule

bind multifunction_pin_control pin_mux_properties i_pin_mux_properties (
  .clk_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o,
  .mutes_i, .adc_overrange_i, .muxed_pin_o);

//--- tb/pin_load.sv
// Board pull-up load on the seven multifunction pins
`timescale 1ns/10ps
module pin_load
  import pin_mux_pkg::*;
(
  // Pins from the device
  input  wire pin_drive_t [6:0] muxed_pin_i,
  // Net level on the board
  output logic [6:0]            pad_o
);
  // Released pins float high through the resistor
  always_comb begin
    for (int i = 0; i < 7; i++)
      pad_o[i] = muxed_pin_i[i].enable_n | muxed_pin_i[i].level;
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the multifunction pin control
`timescale 1ns/10ps
module testbench;
  import pin_mux_pkg::*;
  logic             clk_i, reset_i, write_i, read_i, adc_overrange_i;
  logic [7:0]       addr_i, wdata_i, rdata_o, sh [7];
  channel_mutes_t   mutes_i;
  pin_drive_t [6:0] muxed_pin_o;
  logic [6:0]       pad;
  int               n_mismatch = 0, checks_done = 0;
  logic [31:0]      seed = 81627;
  // Mute masks per pin, function bit 4 down to 0, index 0 is pin 1
  logic [29:0]      mt [7] = '{30'h30303000, 30'h30303000, 30'h30302040,
    30'h30302040, 30'h302040C0, 30'h302040C0, 30'h2040C0C0};
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  multifunction_pin_control i_multifunction_pin_control (.clk_i, .reset_i,
    .addr_i, .wdata_i, .write_i, .read_i, .rdata_o, .mutes_i,
    .adc_overrange_i, .muxed_pin_o);
  pin_load i_pin_load (.muxed_pin_i(muxed_pin_o), .pad_o(pad));
  // ------------------------------
  // Model, bus tasks and checks
  // ------------------------------
  function automatic logic [31:0] nxt();
    seed = seed[0] ? (seed >> 1) ^ 32'hA3000000 : seed >> 1;
    return seed;
  endfunction
  function automatic logic [2:0] model(int i, logic [7:0] c,
                                       logic [5:0] m, logic o);
    logic [5:0] mk;
    mk = 6'h00;
    for (int k = 0; k < 5; k++) if (c[k]) mk |= mt[i][6*k +: 6];
    case (c[7:6])
      2'h0: return 3'h3;
      2'h1: return {((m & mk) == mk) == c[5], 2'h0};
      2'h2: return {1'h0, c[1:0] == 2'h3 && !o, 1'h0};
      default: return 3'h4;
    endcase
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Write strobe for one cycle; a read always follows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a <= 8'h2F) sh[8'h2F - a] = d;
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1;
    @(posedge clk_i);
    write_i <= 0;
  endtask
  // Read with data checked in the following cycle, then all pins
  task automatic rd(input logic [7:0] a);
    addr_i <= a;
    read_i <= 1;
    @(posedge clk_i);
    read_i <= 0;
    @(negedge clk_i);
    chk(rdata_o, a <= 8'h2F ? sh[8'h2F - a] : 8'h00);
    for (int i = 0; i < 7; i++) begin
      chk(8'(muxed_pin_o[i]), 8'(model(i, sh[i], mutes_i, adc_overrange_i)));
      chk(8'(pad[i]), 8'(model(i, sh[i], mutes_i, adc_overrange_i) > 3'h1));
    end
    @(posedge clk_i);
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Reset values, unmapped place, then random configurations
  initial begin
    int p;
    {write_i, read_i, adc_overrange_i, addr_i, wdata_i, mutes_i} = '0;
    reset_i = 1;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    for (int a = 8'h29; a < 8'h31; a++) rd(8'(a));
    wr(8'h30, 8'hFF);
    rd(8'h30);
    repeat (400) begin
      p = nxt() % 7;
      wr(8'h2F - 8'(p), 8'(nxt()));
      mutes_i <= 6'(nxt() | nxt());
      adc_overrange_i <= 1'(nxt());
      rd(8'h2F - 8'(p));
    end
    // Well-behaved software: overflow mode with upper function bits zero
    adc_overrange_i <= 1;
    wr(8'h2F, 8'h83);
    rd(8'h2F);
    end_sim();
  end
  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
endmodule
